// file: src/gpc_ctrl.sv
`timescale 1ns/1ps
// How it works
// - bit 18 clear frames whole frame with chip select, set frames each word.
// - bit 16 enables secondary link on pins 0..2 at 128 kHz word rate.
// - link enabled overrides pins 0..2 settings; pin 3 follows its own bits.
// - each pin has a two-bit mode field at 15:14, 11:10, 7:6, 3:2.
// - mode 00 high impedance, 01 input, 10 driven output, 11 open drain.
// - drive value bits 13, 9, 5, 1 set driven level in output modes.
// - sample bits 12, 8, 4, 0 read pin level in input mode, read only.
// - after reset the register reads zero: pins idle, link off.
module gpc_ctrl #(
    parameter int WORD_PERIOD = gpc_pkg::WORD_PERIOD_CYC,
    parameter int BIT_DIV     = gpc_pkg::BIT_DIV_CYC,
    parameter int DEPTH       = gpc_pkg::FIFO_DEPTH
) (
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    input  wire logic [gpc_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [gpc_pkg::DATA_W-1:0]  regWrData,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    output logic      [gpc_pkg::DATA_W-1:0]  regRdData,
    input  wire logic [gpc_pkg::WORD_W-1:0]  ecgWord,
    input  wire logic                        ecgValid,
    input  wire logic                        ecgFrameEnd,
    output logic                             ecgReady,
    input  wire logic [3:0]                  pinIn,
    output logic      [3:0]                  pinOut,
    output logic      [3:0]                  pinOe
);
    localparam int CW = 16;
    initial begin
        if (WORD_PERIOD < (gpc_pkg::WORD_W + 2) * 2 * BIT_DIV || BIT_DIV < 1
            || WORD_PERIOD >= (1 << CW)) begin
            $error("gpc_ctrl: word period too short for one word");
        end
    end
    typedef struct packed {
        logic [gpc_pkg::DATA_W-1:0] ctrl;
        logic [gpc_pkg::DATA_W-1:0] rdData;
        logic [3:0]                 sampled;
        gpc_pkg::gpc_link_e         link;
        logic [CW-1:0]              wordCnt;
        logic [CW-1:0]              divCnt;
        logic [4:0]                 bitCnt;
        logic [gpc_pkg::WORD_W-1:0] shift;
        logic                       sclk;
        logic                       csN;
        logic                       frameOpen;
        logic                       lastWord;
        logic [3:0]                 pinOut;
        logic [3:0]                 pinOe;
        logic [7:0]                 overflowCnt;
    } gpc_ctrl_s;
    gpc_ctrl_s stReg;
    gpc_ctrl_s stNext;
    logic [gpc_pkg::WORD_W:0] fifoIn;
    logic [gpc_pkg::WORD_W:0] fifoOut;
    logic                     fifoValid;
    logic                     fifoPop;
    logic                     fifoEmpty;
    logic                     fifoInReady;
    logic                     linkOn;
    logic                     wordFraming;
    logic                     wordTick;
    logic                     bitTick;
    function automatic logic [1:0] pinMode(input logic [23:0] c, input int p);
        pinMode = c[p * gpc_pkg::PIN_FIELD_STRIDE + gpc_pkg::MODE_LSB_OFS +: 2];
    endfunction
    function automatic logic pinDrive(input logic [23:0] c, input int p);
        pinDrive = c[p * gpc_pkg::PIN_FIELD_STRIDE + gpc_pkg::DRIVE_BIT_OFS];
    endfunction
    assign fifoIn = {ecgFrameEnd, ecgWord};
    assign ecgReady = fifoInReady;
    gpc_fifo #(
        .WIDTH (gpc_pkg::WORD_W + 1),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .inData    (fifoIn),
        .inValid   (ecgValid && linkOn),
        .inReady   (fifoInReady),
        .outData   (fifoOut),
        .outValid  (fifoValid),
        .outReady  (fifoPop),
        .fifoEmpty (fifoEmpty)
    );
    always_comb begin
        linkOn      = stReg.ctrl[gpc_pkg::LINK_ENABLE_BIT];
        wordFraming = stReg.ctrl[gpc_pkg::WORD_FRAMING_BIT];
        wordTick    = stReg.wordCnt == CW'(WORD_PERIOD - 1);
        bitTick     = stReg.divCnt == CW'(BIT_DIV - 1);
        fifoPop     = 1'b0;
        stNext      = stReg;
        // pin levels taken as synchronous; two register stages (sampled, then the sample bit) for a stable readback
        stNext.sampled = pinIn;
        // register port
        if (regWrite && regAddr == gpc_pkg::PIN_CONTROL_OFS) begin
            // sample bits and reserved bits are not stored
            stNext.ctrl = regWrData & gpc_pkg::WRITABLE_MASK;
        end
        for (int p = 0; p < gpc_pkg::PIN_COUNT; p++) begin
            stNext.ctrl[p * gpc_pkg::PIN_FIELD_STRIDE + gpc_pkg::SAMPLE_BIT_OFS] =
                (pinMode(stReg.ctrl, p) == gpc_pkg::MODE_INPUT)
                && !(linkOn && p < 3) && stReg.sampled[p];
        end
        stNext.rdData = '0;
        if (regRead) begin
            case (regAddr)
                gpc_pkg::PIN_CONTROL_OFS: stNext.rdData = stReg.ctrl;
                gpc_pkg::STREAM_STAT_OFS: stNext.rdData = {14'h0000, fifoEmpty,
                                                           !fifoInReady, stReg.overflowCnt};
                default:                  stNext.rdData = '0;
            endcase
        end
        if (ecgValid && linkOn && !fifoInReady && stReg.overflowCnt != 8'hff) begin
            // dropped when the stream is stalled past the fifo; counted, saturating
            stNext.overflowCnt = stReg.overflowCnt + 8'h01;
        end
        // word rate divider
        stNext.wordCnt = wordTick ? '0 : stReg.wordCnt + 1'b1;
        // secondary link
        case (stReg.link)
            gpc_pkg::GPC_IDLE: begin
                stNext.sclk   = 1'b0;
                stNext.divCnt = '0;
                if (wordTick && fifoValid && linkOn) begin
                    fifoPop          = 1'b1;
                    stNext.shift     = fifoOut[gpc_pkg::WORD_W-1:0];
                    stNext.lastWord  = fifoOut[gpc_pkg::WORD_W];
                    stNext.bitCnt    = 5'(gpc_pkg::WORD_W - 1);
                    stNext.csN       = 1'b0;
                    stNext.frameOpen = 1'b1;
                    stNext.link      = gpc_pkg::GPC_SHIFT;
                end
            end
            gpc_pkg::GPC_SHIFT: begin
                stNext.divCnt = bitTick ? '0 : stReg.divCnt + 1'b1;
                if (bitTick) begin
                    stNext.sclk = !stReg.sclk;
                    if (stReg.sclk) begin
                        stNext.shift = {stReg.shift[gpc_pkg::WORD_W-2:0], 1'b0};
                        if (stReg.bitCnt == '0) begin
                            stNext.link = gpc_pkg::GPC_GAP;
                        end else begin
                            stNext.bitCnt = stReg.bitCnt - 5'h01;
                        end
                    end
                end
            end
            gpc_pkg::GPC_GAP: begin
                stNext.sclk = 1'b0;
                // per-word framing releases after every word, else only at frame end
                if (wordFraming || stReg.lastWord) begin
                    stNext.csN       = 1'b1;
                    stNext.frameOpen = 1'b0;
                end
                stNext.link = gpc_pkg::GPC_IDLE;
            end
            default: stNext.link = gpc_pkg::GPC_IDLE;
        endcase
        if (!linkOn) begin
            // disabling mid-word aborts it; pin 0 then follows its mode bits, so partner sees select rise only if they release it or drive it high
            stNext.link      = gpc_pkg::GPC_IDLE;
            stNext.csN       = 1'b1;
            stNext.sclk      = 1'b0;
            stNext.frameOpen = 1'b0;
        end
        // pin drivers
        for (int p = 0; p < gpc_pkg::PIN_COUNT; p++) begin
            case (pinMode(stNext.ctrl, p))
                gpc_pkg::MODE_OUTPUT: begin
                    stNext.pinOe[p]  = 1'b1;
                    stNext.pinOut[p] = pinDrive(stNext.ctrl, p);
                end
                gpc_pkg::MODE_OPENDRAIN: begin
                    stNext.pinOe[p]  = !pinDrive(stNext.ctrl, p);
                    stNext.pinOut[p] = 1'b0;
                end
                default: begin
                    stNext.pinOe[p]  = 1'b0;
                    stNext.pinOut[p] = 1'b0;
                end
            endcase
        end
        if (stNext.ctrl[gpc_pkg::LINK_ENABLE_BIT]) begin
            // pins 0..2 become chip select, clock, data; pin 3 untouched
            stNext.pinOe[2:0]  = 3'h7;
            stNext.pinOut[0]   = stNext.csN;
            stNext.pinOut[1]   = stNext.sclk;
            stNext.pinOut[2]   = stNext.shift[gpc_pkg::WORD_W-1];
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stReg       <= '0;
            stReg.ctrl  <= gpc_pkg::PIN_CONTROL_RST;
            stReg.csN   <= 1'b1;
            stReg.link  <= gpc_pkg::GPC_IDLE;
        end else begin
            stReg <= stNext;
        end
    end
    assign regRdData = stReg.rdData;
    assign pinOut    = stReg.pinOut;
    assign pinOe     = stReg.pinOe;
endmodule // gpc_ctrl

// file: src/gpc_pkg.sv
package gpc_pkg;
    localparam int          DATA_W          = 24;
    localparam int          ADDR_W          = 8;
    localparam int          PIN_COUNT       = 4;
    localparam logic [7:0]  PIN_CONTROL_OFS = 8'h06;
    localparam logic [7:0]  STREAM_DATA_OFS = 8'h40;
    localparam logic [7:0]  STREAM_STAT_OFS = 8'h41;
    localparam logic [23:0] PIN_CONTROL_RST = 24'h000000;
    localparam int          WORD_FRAMING_BIT = 18;
    localparam int          LINK_ENABLE_BIT  = 16;
    localparam int          PIN_FIELD_STRIDE = 4;
    localparam int          MODE_LSB_OFS     = 2;
    localparam int          DRIVE_BIT_OFS    = 1;
    localparam int          SAMPLE_BIT_OFS   = 0;
    localparam logic [23:0] WRITABLE_MASK   = 24'h05eeee;
    localparam logic [1:0]  MODE_HIGHZ      = 2'h0;
    localparam logic [1:0]  MODE_INPUT      = 2'h1;
    localparam logic [1:0]  MODE_OUTPUT     = 2'h2;
    localparam logic [1:0]  MODE_OPENDRAIN  = 2'h3;
    localparam int          CLK_HZ          = 25000000;
    localparam int          WORD_RATE_HZ    = 128000;
    localparam int          WORD_PERIOD_CYC = CLK_HZ / WORD_RATE_HZ;
    localparam int          BIT_DIV_CYC     = 2;
    localparam int          WORD_W          = 24;
    localparam int          FIFO_DEPTH      = 8;
    typedef enum logic [1:0] {
        GPC_IDLE  = 2'h0,
        GPC_SHIFT = 2'h1,
        GPC_GAP   = 2'h3
    } gpc_link_e;
endpackage

// file: src/gpc_fifo.sv
`timescale 1ns/1ps
module gpc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic                  fifoEmpty
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("gpc_fifo: depth must be a power of two of at least 2");
        end
    end
    typedef struct packed {
        logic [AW:0]      wrPtr;
        logic [AW:0]      rdPtr;
        logic [WIDTH-1:0] head;
        logic             headValid;
    } gpc_fifo_s;
    logic [WIDTH-1:0] memReg [DEPTH];
    gpc_fifo_s stReg;
    gpc_fifo_s stNext;
    logic      push;
    logic      pop;
    logic      load;
    logic [AW:0] count;
    always_comb begin
        count    = stReg.wrPtr - stReg.rdPtr;
        inReady  = count != (AW + 1)'(DEPTH);
        push     = inValid && inReady;
        pop      = stReg.headValid && outReady;
        load     = (count != '0) && (!stReg.headValid || pop);
        stNext   = stReg;
        if (push) begin
            stNext.wrPtr = stReg.wrPtr + 1'b1;
        end
        if (load) begin
            stNext.head      = memReg[stReg.rdPtr[AW-1:0]];
            stNext.headValid = 1'b1;
            stNext.rdPtr     = stReg.rdPtr + 1'b1;
        end else if (pop) begin
            stNext.headValid = 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stReg <= '0;
        end else begin
            stReg <= stNext;
        end
        if (push) begin
            memReg[stReg.wrPtr[AW-1:0]] <= inData;
        end
    end
    assign outData   = stReg.head;
    assign outValid  = stReg.headValid;
    assign fifoEmpty = !stReg.headValid && (count == '0);
endmodule // gpc_fifo

// file: tb/gpc_ctrl_asserts.sv
`timescale 1ns/1ps
module gpc_ctrl_asserts (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [7:0]  regAddr,
    input wire logic [23:0] regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [23:0] regRdData,
    input wire logic [3:0]  pinIn,
    input wire logic [3:0]  pinOut,
    input wire logic [3:0]  pinOe
);
    logic [23:0] ctl;
    logic [6:0]  bitCount;
    logic        sclkPrev;
    logic        linkOn;
    logic        ctlRd;
    assign linkOn = ctl[16];
    assign ctlRd  = regRead && regAddr == gpc_pkg::PIN_CONTROL_OFS;
    function automatic logic oeOf(input logic [3:0] f);
        return f[3] & ~(f[2] & f[1]);
    endfunction
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge core_clk) begin
        sclkPrev <= pinOut[1];
        if (reset) begin
            ctl <= 24'h000000;
        end else if (regWrite && regAddr == gpc_pkg::PIN_CONTROL_OFS) begin
            ctl <= regWrData & gpc_pkg::WRITABLE_MASK;
        end
        // bits seen while select is low; cleared the edge after it rises
        if (reset || pinOut[0]) begin
            bitCount <= 7'h00;
        end else if (pinOut[1] && !sclkPrev) begin
            bitCount <= bitCount + 7'h01;
        end
    end
    chk_pin3_mode:
    assert property (pinOe[3] == oeOf(ctl[15:12])) else $error("pin 3 enable wrong");
    chk_low_pins_mode:
    assert property (!linkOn |-> pinOe[2:0] == {oeOf(ctl[11:8]), oeOf(ctl[7:4]), oeOf(ctl[3:0])})
        else $error("pin enables wrong");
    chk_link_takeover:
    assert property (linkOn |-> pinOe[2:0] == 3'h7) else $error("link pins not driven");
    chk_drive_level:
    assert property (((pinOut ^ {ctl[13], ctl[9], ctl[5], ctl[1]}) & pinOe
        & (linkOn ? 4'h8 : 4'hf)) == 4'h0) else $error("driven level wrong");
    chk_read_ctl:
    assert property (ctlRd |=> (regRdData & gpc_pkg::WRITABLE_MASK) == $past(ctl))
        else $error("readback wrong");
    chk_read_idle:
    assert property (!ctlRd && !(regRead && regAddr == gpc_pkg::STREAM_STAT_OFS)
        |=> regRdData == 24'h000000) else $error("read data not zero");
    chk_sample_bit:
    assert property (ctlRd && ctl[15:14] == 2'h1 && $past(ctl[15:14]) == 2'h1
        && $stable(pinIn[3]) && $past(pinIn[3], 2) == pinIn[3]
        |=> regRdData[12] == $past(pinIn[3])) else $error("sampled bit wrong");
    chk_word_framing:
    assert property (linkOn && $past(linkOn) && $rose(pinOut[0]) |->
        (ctl[18] ? bitCount == 7'h18 : bitCount != 7'h00 && bitCount % 7'h18 == 7'h00))
        else $error("select framing wrong");
endmodule // gpc_ctrl_asserts
bind gpc_ctrl gpc_ctrl_asserts chk (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

// file: tb/gpc_pin_model.sv
`timescale 1ns/1ps
module gpc_pin_model (
    input  wire logic        core_clk,
    input  wire logic [3:0]  pinOut,
    input  wire logic [3:0]  pinOe,
    input  wire logic [3:0]  extLevel,
    input  wire logic [3:0]  extDrive,
    output logic      [3:0]  pinIn,
    output logic      [23:0] rxWord,
    output logic      [7:0]  rxCount
);
    logic [23:0] shiftReg = 24'h000000;
    logic [4:0]  bitIdx   = 5'h00;
    logic        sclkPrev = 1'b0;
    // pull-ups on the board: an undriven pin reads high
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pinIn[i] = pinOe[i] ? pinOut[i] : (extDrive[i] ? extLevel[i] : 1'b1);
        end
    end
    initial begin
        rxWord = 24'h000000;
        rxCount = 8'h00;
    end
    always @(posedge core_clk) begin
        sclkPrev <= pinIn[1];
        if (pinIn[0]) begin
            bitIdx <= 5'h00;
        end else if (pinIn[1] && !sclkPrev) begin
            shiftReg <= {shiftReg[22:0], pinIn[2]};
            bitIdx <= (bitIdx == 5'h17) ? 5'h00 : bitIdx + 5'h01;
            if (bitIdx == 5'h17) begin
                rxWord <= {shiftReg[22:0], pinIn[2]};
                rxCount <= rxCount + 8'h01;
            end
        end
    end
endmodule // gpc_pin_model

// file: tb/tb_gpc_ctrl.sv
`timescale 1ns/1ps
module tb_gpc_ctrl;
    localparam logic [7:0] CTL = gpc_pkg::PIN_CONTROL_OFS;
    logic        core_clk    = 1'b0;
    logic        reset       = 1'b1;
    logic [7:0]  regAddr     = 8'h00;
    logic [23:0] regWrData   = 24'h000000;
    logic        regWrite    = 1'b0;
    logic        regRead     = 1'b0;
    logic [23:0] ecgWord     = 24'h000000;
    logic        ecgValid    = 1'b0;
    logic        ecgFrameEnd = 1'b0;
    logic [3:0]  extLevel    = 4'h0;
    logic [3:0]  extDrive    = 4'h0;
    logic [23:0] regRdData, rxWord, rdVal;
    logic [3:0]  pinIn, pinOut, pinOe;
    logic [7:0]  rxCount, base;
    logic        ecgReady, sawFull;
    int          badCount    = 0;
    int          totalChecks = 0;
    always #20 core_clk = ~core_clk;
    // short word period keeps the run brief
    gpc_ctrl #(.WORD_PERIOD(104)) uut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .ecgWord(ecgWord), .ecgValid(ecgValid), .ecgFrameEnd(ecgFrameEnd),
        .ecgReady(ecgReady), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
    gpc_pin_model far (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
        .extLevel(extLevel), .extDrive(extDrive), .pinIn(pinIn), .rxWord(rxWord),
        .rxCount(rxCount));
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (badCount == 0 && totalChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // strobe then one idle edge, so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        // read data stand for this one cycle only; taken mid-cycle, away from the edge
        @(negedge core_clk);
        rdVal = regRdData;
        @(posedge core_clk);
    endtask
    // valid stays up between words; caller drops it after the last
    task automatic push(input logic [23:0] w, input logic last);
        ecgWord <= w;
        ecgFrameEnd <= last;
        ecgValid <= 1'b1;
        @(posedge core_clk);
        for (int n = 0; n < 400 && ecgReady !== 1'b1; n++) begin
            sawFull = 1'b1;
            @(posedge core_clk);
        end
    endtask
    task automatic wait_rx(input logic [7:0] target);
        for (int n = 0; n < 4000 && rxCount !== target; n++) begin
            @(posedge core_clk);
        end
        check({16'h0000, rxCount}, {16'h0000, target});
    endtask
    task automatic t_reset;
        rd(CTL);
        check(rdVal, gpc_pkg::PIN_CONTROL_RST);
        check({20'h00000, pinOe}, 24'h000000);
        rd(8'h07);
        check(rdVal, 24'h000000);
    endtask
    task automatic t_modes;
        logic [15:0] d;
        logic        oe;
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 2; v++) begin
                d = {4{m[1:0], v[0], 1'b0}};
                oe = (m == 2) || (m == 3 && v == 0);
                wr(CTL, {8'h00, d});
                check({20'h00000, pinOe}, {20'h00000, {4{oe}}});
                check({20'h00000, pinOut & pinOe}, {20'h00000, {4{oe & v[0]}}});
                rd(CTL);
                check(rdVal, {8'h00, d} | (m == 1 ? 24'h001111 : 24'h000000));
            end
        end
    endtask
    task automatic t_input;
        extDrive <= 4'hf;
        extLevel <= 4'h5;
        wr(CTL, 24'h004444);
        rd(CTL);
        check(rdVal, 24'h004545);
        extLevel <= 4'ha;
        wr(CTL, 24'h001111);
        rd(CTL);
        check(rdVal, 24'h000000);
        wr(CTL, 24'h004444);
        rd(CTL);
        check(rdVal, 24'h005454);
        extDrive <= 4'h0;
    endtask
    task automatic t_link;
        base = rxCount;
        sawFull = 1'b0;
        wr(CTL, 24'h05a444);
        check({20'h00000, pinOe}, 24'h00000f);
        check({23'h000000, pinOut[3]}, 24'h000001);
        // pins 0..2 set to input but driven by the link, so their sample bits stay clear
        rd(CTL);
        check(rdVal, 24'h05a444);
        // eleven words overrun fifo and head even if one word leaves mid-burst
        for (int i = 0; i < 11; i++) begin
            push(24'h3c5a00 + 24'(i), 1'b0);
        end
        ecgValid <= 1'b0;
        check({23'h000000, sawFull}, 24'h000001);
        wait_rx(base + 8'h0b);
        check(rxWord, 24'h3c5a0a);
        wr(CTL, 24'h01a000);
        for (int i = 0; i < 3; i++) begin
            push(24'ha50f00 + 24'(i), i == 2);
        end
        ecgValid <= 1'b0;
        wait_rx(base + 8'h0e);
        check(rxWord, 24'ha50f02);
        rd(gpc_pkg::STREAM_STAT_OFS);
        check(rdVal & 24'h000300, 24'h000200);
        wr(CTL, 24'h000000);
        check({20'h00000, pinOe}, 24'h000000);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_modes();
        t_input();
        t_link();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        badCount++;
        report_and_stop();
    end
endmodule // tb_gpc_ctrl
